//--- design/acp_cfg.svh
// register offsets, reset values, bit positions and frame characters of the
// ascii command parser; definitions only, included by the design modules
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH
// avalon word addresses
`define ACP_REG_CTRL 3'h0
`define ACP_REG_STAT 3'h1
`define ACP_REG_LATCH 3'h2
// control register layout and reset values, and the edge mask reset value
`define ACP_CHK_BIT 8
`define ACP_ADDR_RST 8'h01
`define ACP_CHK_RST 1'b0
`define ACP_EMASK_RST 8'h00
// frame characters
`define ACP_CH_DOLLAR 8'h24
`define ACP_CH_TILDE 8'h7E
`define ACP_CH_CR 8'h0D
`define ACP_CH_ACK 8'h21
`define ACP_CH_NAK 8'h3F
`define ACP_CH_ZERO 8'h30
`define ACP_CH_ONE 8'h31
// command letters
`define ACP_CMD_EDGE 8'h45
`define ACP_CMD_FW 8'h46
`define ACP_CMD_SW 8'h49
`define ACP_CMD_LATCH 8'h4C
`define ACP_CMD_CLEAR 8'h43
`define ACP_CMD_NAME 8'h4D
`define ACP_CMD_PROTO 8'h50
`define ACP_CMD_SETNAME 8'h4F
// buffer sizes
`define ACP_RX_MAX 16
`define ACP_TX_MAX 16
`endif

//--- design/acp_pkg.sv
// shared types and the hex digit helper of the ascii command parser
// assumes nothing of its surroundings
package acp_pkg;
   typedef enum logic [2:0] {S_IDLE, S_COLLECT, S_DECODE, S_EMIT, S_DONE} acp_state_t;
   typedef enum logic [2:0] {K_ACK, K_NAK, K_EDGE, K_FW, K_SW, K_LATCH, K_NAME, K_PROTO}
      acp_reply_t;
   // nibble to upper-case ascii hex digit
   function automatic logic [7:0] acp_hex_char(input logic [3:0] n);
      return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction
endpackage

//--- design/acp_tx_if.sv
// reply character hand-off between the parser and the reply sender
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface acp_tx_if;
   logic push;
   logic [7:0] ch;
   logic done;
   logic chk_en;
   logic busy;
   modport parser (output push, output ch, output done, output chk_en, input busy);
   modport sender (input push, input ch, input done, input chk_en, output busy);
endinterface
`default_nettype wire

//--- design/acp_sender.sv
// reply sender: buffers one reply, appends checksum and terminator, streams bytes
// assumes pushes arrive only while busy is low, closed by a done pulse
`timescale 1ns/1ps
`default_nettype none
`include "acp_cfg.svh"
module acp_sender #(
   parameter int DEPTH = `ACP_TX_MAX
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   acp_tx_if.sender tx_if,
   input wire logic tx_ready_in,
   output logic tx_valid_out,
   output logic [7:0] tx_data_out
);
   import acp_pkg::*;
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [AW:0] wr;
      logic [AW:0] rd;
      logic [7:0] sum;
      logic [1:0] tail;
      logic send;
      logic valid;
      logic [7:0] data;
   } acp_snd_t;
   acp_snd_t s;
   acp_snd_t nxt;

   if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_depth_chk
      $error("acp_sender: DEPTH must be a power of two of at least 16");
   end

   // next state: fill while idle, then drain one byte per accepted beat
   always_comb
   begin
      nxt = s;
      if (s.valid && tx_ready_in)
         nxt.valid = 1'b0;
      // running sum covers every reply character ahead of the checksum
      if (!s.send && tx_if.push)
      begin
         nxt.mem[s.wr[AW-1:0]] = tx_if.ch;
         nxt.wr = s.wr + 1'b1;
         nxt.sum = s.sum + tx_if.ch;
      end
      if (!s.send && tx_if.done)
      begin
         nxt.send = 1'b1;
         nxt.tail = tx_if.chk_en ? 2'h0 : 2'h2;
      end
      // body first, then two checksum digits, then the terminator
      if (s.send && (!s.valid || tx_ready_in))
      begin
         if (s.rd != s.wr)
         begin
            nxt.data = s.mem[s.rd[AW-1:0]];
            nxt.valid = 1'b1;
            nxt.rd = s.rd + 1'b1;
         end
         else
         begin
            case (s.tail)
               2'h0: nxt.data = acp_hex_char(s.sum[7:4]);
               2'h1: nxt.data = acp_hex_char(s.sum[3:0]);
               2'h2: nxt.data = `ACP_CH_CR;
               default: nxt.data = s.data;
            endcase
            nxt.valid = (s.tail != 2'h3);
            nxt.tail = (s.tail == 2'h3) ? 2'h3 : s.tail + 2'h1;
            if (s.tail == 2'h3)
            begin
               nxt.send = 1'b0;
               nxt.wr = '0;
               nxt.rd = '0;
               nxt.sum = 8'h00;
            end
         end
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         s <= '0;
      else
         s <= nxt;
   end

   assign tx_valid_out = s.valid;
   assign tx_data_out = s.data;
   assign tx_if.busy = s.send;

   a_cr_closes: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $fell(s.send) |-> s.data == `ACP_CH_CR && !s.valid)
      else $error("reply closed without terminator");

   a_chk_digit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s.send && s.rd == s.wr && s.tail == 2'h1 && (!s.valid || tx_ready_in)
      |=> s.valid && s.data == acp_hex_char(s.sum[3:0]) ##0 s.tail == 2'h2)
      else $error("checksum low digit wrong");
endmodule
`default_nettype wire

//--- design/acp_top.sv
// ascii command parser: collects addressed frames from a byte stream, decodes
// the edge, firmware, switch, latch, name and protocol commands, builds replies.
// assumes rx bytes come from a receiver on core_clk_in, one per rx_valid_in pulse.
// Notes on behaviour
// - frame is delimiter, two hex address digits, command, optional checksum, terminator.
// - accepted reply opens with '!' and address; rejected gives '?' and address.
// - bad syntax, receive error or foreign address produce no reply at all.
// - edge set stores hex mask, bit i for channel i, 1 rising, then acknowledges.
// - edge query returns the stored mask as two hex digits after the address.
// - firmware query returns the version string after the address.
// - switch query returns '0' in setup position, '1' in normal position.
// - latch query selector '0' reads low latches, '1' reads high latches.
// - latch reply is '!', four hex digits output then input, then "00", no address.
// - latch query with any other selector is rejected with address.
// - latch clear reloads every latch from the present levels, so the next query reads only those.
// - name query returns the stored name after the address.
// - tilde name set replaces the stored name and acknowledges.
// - protocol query gives support digit then stored selection digit.
// - reported selection is the stored one, not the one running now.
// - protocol set takes one digit, 0 native, 1 modbus, written to storage.
// - protocol change only in setup position, else rejected; effective after power-up.
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acp_cfg.svh"
module acp_top #(
   parameter int NAME_MAX = 8,
   parameter logic [8*NAME_MAX-1:0] NAME_RST = "IO-NODE1",
   parameter int FW_LEN = 4,
   parameter logic [8*FW_LEN-1:0] FW_STR = "B0.3", // arbitrary version text
   parameter logic MODBUS_OK = 1'b1
) (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic [2:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   input wire logic rx_err_in,
   input wire logic tx_ready_in,
   output logic tx_valid_out,
   output logic [7:0] tx_data_out,
   input wire logic [7:0] di_pins_in,
   input wire logic [7:0] do_state_in,
   input wire logic setup_sw_n_in,
   input wire logic proto_nv_in,
   output logic nv_wr_out,
   output logic nv_data_out,
   output logic proto_run_out,
   output logic [7:0] edge_mask_out
);
   import acp_pkg::*;
   typedef struct packed {
      acp_state_t st;
      logic [`ACP_RX_MAX-1:0][7:0] rx;
      logic [4:0] len;
      logic [7:0] sum;
      logic [7:0] delim;
      logic bad;
      acp_reply_t kind;
      logic [4:0] idx;
      logic [15:0] lat;
      logic [NAME_MAX-1:0][7:0] name;
      logic [3:0] nlen;
      logic [7:0] addr;
      logic chk_en;
      logic [7:0] emask;
      logic proto;
      logic proto_run;
      logic init;
      logic [1:0] sw;
      logic [7:0] di_m;
      logic [7:0] di_s;
      logic [7:0] hi_di;
      logic [7:0] hi_do;
      logic [7:0] lo_di;
      logic [7:0] lo_do;
      logic push;
      logic [7:0] ch;
      logic done;
      logic nv_wr;
      logic wreq;
      logic [31:0] rdata;
   } acp_st_t;
   acp_st_t s;
   acp_st_t nxt;
   logic [1:0] rsync_ff;
   logic rst_n;
   acp_tx_if tx_if();

   if (NAME_MAX < 1 || NAME_MAX > 12 || FW_LEN < 1 || FW_LEN > 12)
   begin : g_len_chk
      $error("acp_top: NAME_MAX and FW_LEN must lie in 1..12");
   end

   // ascii hex digit to {valid, value}
   function automatic logic [4:0] hex_val(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39)
         return {1'b1, c[3:0]};
      if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
         return {1'b1, c[3:0] + 4'h9};
      return 5'h00;
   endfunction

   // reply length before checksum and terminator
   function automatic logic [4:0] reply_len(input acp_st_t t);
      case (t.kind)
         K_EDGE, K_PROTO: return 5'd5;
         K_FW: return 5'(3 + FW_LEN);
         K_SW: return 5'd4;
         K_LATCH: return 5'd7;
         K_NAME: return 5'd3 + {1'b0, t.nlen};
         default: return 5'd3;
      endcase
   endfunction

   // character at position idx of the reply being emitted
   function automatic logic [7:0] reply_char(input acp_st_t t);
      logic [7:0] c;
      logic [4:0] p;
      c = `ACP_CH_ACK;
      p = t.idx - 5'd3;
      if (t.idx == 5'd0)
         c = (t.kind == K_NAK) ? `ACP_CH_NAK : `ACP_CH_ACK;
      else if (t.kind == K_LATCH)
      begin
         // latch replies carry no address field
         case (t.idx)
            5'd1: c = acp_hex_char(t.lat[15:12]);
            5'd2: c = acp_hex_char(t.lat[11:8]);
            5'd3: c = acp_hex_char(t.lat[7:4]);
            5'd4: c = acp_hex_char(t.lat[3:0]);
            default: c = `ACP_CH_ZERO;
         endcase
      end
      else if (t.idx == 5'd1)
         c = acp_hex_char(t.addr[7:4]);
      else if (t.idx == 5'd2)
         c = acp_hex_char(t.addr[3:0]);
      else
      begin
         case (t.kind)
            K_EDGE: c = acp_hex_char(p[0] ? t.emask[3:0] : t.emask[7:4]);
            K_FW: c = FW_STR[8*(FW_LEN-1-int'(p)) +: 8];
            K_SW: c = t.sw[1] ? `ACP_CH_ONE : `ACP_CH_ZERO;
            K_NAME: c = t.name[NAME_MAX-1-int'(p)];
            K_PROTO: c = (p[0] ? t.proto : MODBUS_OK) ? `ACP_CH_ONE : `ACP_CH_ZERO;
            default: c = `ACP_CH_ACK;
         endcase
      end
      return c;
   endfunction

   // frame decode terms; with checksum on the last two characters are the checksum
   logic [4:0] plen;
   logic [7:0] psum;
   logic [4:0] hv0;
   logic [4:0] hv1;
   logic [4:0] hv3;
   logic [4:0] hv4;
   logic [4:0] hc0;
   logic [4:0] hc1;
   logic [7:0] cmd;
   logic [7:0] arg;
   logic [7:0] edge_arg;
   logic chk_ok;
   logic frame_ok;
   logic is_dollar;
   logic sel_ok;
   logic busy;
   assign plen = s.chk_en ? s.len - 5'd2 : s.len;
   assign psum = s.sum - s.rx[4'(s.len - 5'd1)] - s.rx[4'(s.len - 5'd2)];
   assign hc0 = hex_val(s.rx[4'(s.len - 5'd2)]);
   assign hc1 = hex_val(s.rx[4'(s.len - 5'd1)]);
   assign hv0 = hex_val(s.rx[0]);
   assign hv1 = hex_val(s.rx[1]);
   assign hv3 = hex_val(s.rx[3]);
   assign hv4 = hex_val(s.rx[4]);
   assign cmd = s.rx[2];
   assign arg = s.rx[3];
   assign edge_arg = {hv3[3:0], hv4[3:0]};
   assign chk_ok = !s.chk_en || (s.len >= 5'd2 && hc0[4] && hc1[4]
      && {hc0[3:0], hc1[3:0]} == psum);
   assign frame_ok = chk_ok && !s.bad && plen >= 5'd3 && plen <= 5'd16
      && hv0[4] && hv1[4] && {hv0[3:0], hv1[3:0]} == s.addr;
   assign is_dollar = (s.delim == `ACP_CH_DOLLAR);
   assign sel_ok = (arg == `ACP_CH_ZERO || arg == `ACP_CH_ONE);
   assign busy = (s.st != S_IDLE) || tx_if.busy;

   // next state of the whole block
   always_comb
   begin
      nxt = s;
      nxt.push = 1'b0;
      nxt.done = 1'b0;
      nxt.nv_wr = 1'b0;
      nxt.sw = {s.sw[0], setup_sw_n_in};
      nxt.di_m = di_pins_in;
      nxt.di_s = s.di_m;
      // latches collect until cleared
      nxt.hi_di = s.hi_di | s.di_s;
      nxt.hi_do = s.hi_do | do_state_in;
      nxt.lo_di = s.lo_di | ~s.di_s;
      nxt.lo_do = s.lo_do | ~do_state_in;
      // storage value is picked up once after reset and never again for the run copy
      if (!s.init)
      begin
         nxt.init = 1'b1;
         nxt.proto = proto_nv_in;
         nxt.proto_run = proto_nv_in;
      end
      case (s.st)
         S_IDLE, S_COLLECT:
         begin
            if (rx_valid_in)
            begin
               if (rx_data_in == `ACP_CH_DOLLAR || rx_data_in == `ACP_CH_TILDE)
               begin
                  // any delimiter restarts the frame
                  nxt.st = S_COLLECT;
                  nxt.len = 5'd0;
                  nxt.sum = rx_data_in;
                  nxt.delim = rx_data_in;
                  nxt.bad = rx_err_in;
               end
               else if (s.st == S_COLLECT && rx_data_in == `ACP_CH_CR)
               begin
                  nxt.st = S_DECODE;
                  nxt.bad = s.bad | rx_err_in;
               end
               else if (s.st == S_COLLECT)
               begin
                  nxt.sum = s.sum + rx_data_in;
                  nxt.bad = s.bad | rx_err_in | (s.len == 5'd16);
                  if (s.len != 5'd16)
                  begin
                     nxt.rx[s.len[3:0]] = rx_data_in;
                     nxt.len = s.len + 5'd1;
                  end
               end
            end
         end
         S_DECODE:
         begin
            nxt.st = S_EMIT;
            nxt.idx = 5'd0;
            nxt.kind = K_NAK;
            if (!frame_ok)
               nxt.st = S_IDLE;
            else if (!is_dollar)
            begin
               if (cmd == `ACP_CMD_SETNAME && plen - 5'd3 <= 5'(NAME_MAX))
               begin
                  nxt.kind = K_ACK;
                  nxt.nlen = 4'(plen - 5'd3);
                  for (int i = 0; i < NAME_MAX; i++)
                     nxt.name[NAME_MAX-1-i] = s.rx[4'(3 + i)];
               end
            end
            else
            begin
               case (cmd)
                  `ACP_CMD_EDGE:
                  begin
                     if (plen == 5'd3)
                        nxt.kind = K_EDGE;
                     else if (plen == 5'd5 && hv3[4] && hv4[4])
                     begin
                        nxt.emask = edge_arg;
                        nxt.kind = K_ACK;
                     end
                     else if (plen == 5'd5)
                        nxt.st = S_IDLE;
                  end
                  `ACP_CMD_FW:
                     if (plen == 5'd3)
                        nxt.kind = K_FW;
                  `ACP_CMD_SW:
                     if (plen == 5'd3)
                        nxt.kind = K_SW;
                  `ACP_CMD_LATCH:
                  begin
                     if (plen == 5'd4 && sel_ok)
                     begin
                        nxt.kind = K_LATCH;
                        nxt.lat = arg[0] ? {s.hi_do, s.hi_di} : {s.lo_do, s.lo_di};
                     end
                     else
                        nxt.kind = K_NAK;
                  end
                  `ACP_CMD_CLEAR:
                  begin
                     if (plen == 5'd3)
                     begin
                        // a level present in the clearing cycle stays latched
                        nxt.kind = K_ACK;
                        nxt.hi_di = s.di_s;
                        nxt.hi_do = do_state_in;
                        nxt.lo_di = ~s.di_s;
                        nxt.lo_do = ~do_state_in;
                     end
                  end
                  `ACP_CMD_NAME:
                     if (plen == 5'd3)
                        nxt.kind = K_NAME;
                  `ACP_CMD_PROTO:
                  begin
                     if (plen == 5'd3)
                        nxt.kind = K_PROTO;
                     else if (plen == 5'd4 && sel_ok && !s.sw[1] && (MODBUS_OK || !arg[0]))
                     begin
                        nxt.kind = K_ACK;
                        nxt.proto = arg[0];
                        nxt.nv_wr = 1'b1;
                     end
                  end
                  default:
                     nxt.kind = K_NAK;
               endcase
            end
         end
         S_EMIT:
         begin
            // hold off while the previous reply is still leaving
            if (!tx_if.busy)
            begin
               nxt.push = 1'b1;
               nxt.ch = reply_char(s);
               nxt.idx = s.idx + 5'd1;
               if (s.idx == reply_len(s) - 5'd1)
                  nxt.st = S_DONE;
            end
         end
         S_DONE:
         begin
            nxt.done = 1'b1;
            nxt.st = S_IDLE;
         end
         default:
            nxt.st = S_IDLE;
      endcase
      // avalon slave: one wait cycle, read data captured, write lands on the release edge
      nxt.wreq = !((avs_read_in || avs_write_in) && s.wreq);
      if (avs_read_in && s.wreq)
      begin
         case (avs_address_in)
            `ACP_REG_CTRL: nxt.rdata = {23'h0, s.chk_en, s.addr};
            `ACP_REG_STAT: nxt.rdata = {20'h0, busy, !s.sw[1], s.proto_run, s.proto, s.emask};
            `ACP_REG_LATCH: nxt.rdata = {s.lo_do, s.lo_di, s.hi_do, s.hi_di};
            default: nxt.rdata = 32'h0;
         endcase
      end
      if (avs_write_in && !s.wreq && avs_address_in == `ACP_REG_CTRL)
      begin
         if (avs_byteenable_in[0])
            nxt.addr = avs_writedata_in[7:0];
         if (avs_byteenable_in[1])
            nxt.chk_en = avs_writedata_in[`ACP_CHK_BIT];
      end
   end

   // reset release through two stages
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         rsync_ff <= 2'h0;
      else
         rsync_ff <= {rsync_ff[0], 1'b1};
   end
   assign rst_n = rsync_ff[1];

   // state register
   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.name <= NAME_RST;
         s.nlen <= 4'(NAME_MAX);
         s.addr <= `ACP_ADDR_RST;
         s.chk_en <= `ACP_CHK_RST;
         s.emask <= `ACP_EMASK_RST;
         s.sw <= 2'h3;
         s.wreq <= 1'b1;
      end
      else
         s <= nxt;
   end

   assign tx_if.push = s.push;
   assign tx_if.ch = s.ch;
   assign tx_if.done = s.done;
   assign tx_if.chk_en = s.chk_en;
   assign avs_readdata_out = s.rdata;
   assign avs_waitrequest_out = s.wreq;
   assign nv_wr_out = s.nv_wr;
   assign nv_data_out = s.proto;
   assign proto_run_out = s.proto_run;
   assign edge_mask_out = s.emask;

   acp_sender #(.DEPTH(`ACP_TX_MAX)) u_sender (
      .clk_in(core_clk_in),
      .rst_n_in(rst_n),
      .tx_if(tx_if),
      .tx_ready_in(tx_ready_in),
      .tx_valid_out(tx_valid_out),
      .tx_data_out(tx_data_out)
   );

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n);
   sequence dec_seen;
      s.st == S_DECODE && frame_ok && is_dollar;
   endsequence
   sequence nak_head;
      s.st == S_EMIT && s.idx == 5'd0 && !tx_if.busy && s.kind == K_NAK;
   endsequence

   a_silent_drop: assert property (s.st == S_DECODE && !frame_ok
      |=> s.st == S_IDLE && !s.push ##1 !s.done) else $error("dropped frame answered");
   a_edge_store: assert property (dec_seen and cmd == `ACP_CMD_EDGE && plen == 5'd5
      && hv3[4] && hv4[4] |=> s.emask == $past(edge_arg) && s.kind == K_ACK)
      else $error("edge mask not stored");
   a_nak_reply: assert property (nak_head |=> s.ch == `ACP_CH_NAK
      ##1 s.ch == acp_hex_char(s.addr[7:4])) else $error("reject reply malformed");
   a_latch_tail: assert property (s.st == S_EMIT && s.kind == K_LATCH && s.idx == 5'd5
      && !tx_if.busy |=> s.ch == `ACP_CH_ZERO ##1 s.ch == `ACP_CH_ZERO && s.push ##1 s.done)
      else $error("latch reply tail wrong");
   a_sel_reject: assert property (dec_seen and cmd == `ACP_CMD_LATCH && !sel_ok
      |=> s.kind == K_NAK && s.st == S_EMIT) else $error("bad selector accepted");
   a_latch_clear: assert property (dec_seen and cmd == `ACP_CMD_CLEAR && plen == 5'd3
      |=> s.hi_di == $past(s.di_s) && s.lo_di == ~$past(s.di_s)) else $error("latch not cleared");
   a_proto_lock: assert property (dec_seen and cmd == `ACP_CMD_PROTO && plen == 5'd4
      && s.sw[1] |=> s.kind == K_NAK && $stable(s.proto) && !s.nv_wr)
      else $error("protocol changed outside setup");
   a_proto_store: assert property (dec_seen and cmd == `ACP_CMD_PROTO && plen == 5'd4
      && sel_ok && !s.sw[1] && arg == `ACP_CH_ZERO |=> s.nv_wr && !nv_data_out ##1 !s.nv_wr)
      else $error("protocol not written");
   a_run_fixed: assert property (s.init |=> $stable(s.proto_run))
      else $error("running protocol moved");
endmodule
`default_nettype wire

//--- verification/acp_host.sv
// host model: gathers reply bytes into a string, ready steady or toggling
// assumes the reply stream runs on the bench clock
`timescale 1ns/1ps
`default_nettype none
module acp_host (
   input wire logic clk_in,
   input wire logic slow_in,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   output logic tx_ready_out
);
   string got = "";
   initial tx_ready_out = 1'b0;
   // slow mode stalls every other cycle, so held bytes get exercised
   always @(posedge clk_in)
   begin
      if (tx_valid_in && tx_ready_out)
         got = $sformatf("%s%c", got, tx_data_in);
      tx_ready_out <= slow_in ? !tx_ready_out : 1'b1;
   end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// bench: sends command frames and register accesses, checks the replies
// assumes the host model sinks replies and a 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic core_clk_in = 1'b0, reset_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic rx_valid_in = 1'b0, rx_err_in = 1'b0, tx_ready_in, tx_valid_out, avs_waitrequest_out;
   logic setup_sw_n_in = 1'b1, proto_nv_in = 1'b0, proto_run_out, slow = 1'b0;
   logic nv_wr_out, nv_data_out;
   logic [2:0] avs_address_in = 3'h0;
   logic [3:0] avs_byteenable_in = 4'hF;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
   logic [7:0] rx_data_in = 8'h00, tx_data_out, edge_mask_out;
   logic [7:0] di_pins_in = 8'h02, do_state_in = 8'h01;
   int errors = 0, checks_done = 0, nv_writes = 0;
   acp_top dut (.core_clk_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
      .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
      .rx_valid_in, .rx_data_in, .rx_err_in, .tx_ready_in, .tx_valid_out, .tx_data_out,
      .di_pins_in, .do_state_in, .setup_sw_n_in, .proto_nv_in, .nv_wr_out,
      .nv_data_out, .proto_run_out, .edge_mask_out);
   acp_host host (.clk_in(core_clk_in), .slow_in(slow), .tx_valid_in(tx_valid_out),
      .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in));
   initial forever #20 core_clk_in = !core_clk_in;
   // storage write pulses, so refused protocol sets show up as a missing count
   always @(posedge core_clk_in)
   begin
      if (nv_wr_out)
         nv_writes++;
   end
   task automatic check(input string what, input string seen, input string exp);
      checks_done++;
      if (seen != exp)
      begin
         errors++;
         $display("BAD %s expected %s seen %s", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // whole frame back to back, terminator last; a silent case waits the full bound
   task automatic run(input string cmd, input string exp);
      int n;
      host.got = "";
      foreach (cmd[i])
      begin
         rx_valid_in <= 1'b1;
         rx_data_in <= cmd[i];
         @(posedge core_clk_in);
      end
      rx_data_in <= 8'h0D;
      @(posedge core_clk_in);
      rx_valid_in <= 1'b0;
      n = 0;
      while (!(host.got.len() > 0 && host.got[host.got.len()-1] == 8'h0D) && n < 300)
      begin
         @(posedge core_clk_in);
         n++;
      end
      @(posedge core_clk_in);
      check(cmd, host.got, exp == "" ? "" : {exp, "\r"});
      // an expected reply that never ended is a hang: stop here
      if (n >= 300 && exp != "")
         print_verdict();
      $display("test %s done", cmd);
   endtask
   // request held until waitrequest is seen low at an edge
   task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      do
      begin
         @(posedge core_clk_in);
         n++;
      end
      while (avs_waitrequest_out !== 1'b0 && n < 20);
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge core_clk_in);
      if (n >= 20)
      begin
         errors++;
         print_verdict();
      end
   endtask
   initial
   begin
      repeat (10) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      repeat (5) @(posedge core_clk_in);
      run("$01E3A", "!01");
      run("$01E", "!013A");
      check("mask", $sformatf("%h", edge_mask_out), "3a");
      run("$01F", "!01B0.3");
      setup_sw_n_in <= 1'b0;
      slow <= 1'b1;
      run("$01I", "!010");
      run("$01P0", "!01");
      run("$01P1", "!01");
      run("$01P", "!0111");
      check("run", $sformatf("%b", proto_run_out), "0");
      check("nv", $sformatf("%b%0d", nv_data_out, nv_writes), "12");
      setup_sw_n_in <= 1'b1;
      slow <= 1'b0;
      run("$01I", "!011");
      run("$01P0", "?01");
      check("nv lock", $sformatf("%b%0d", nv_data_out, nv_writes), "12");
      run("$01C", "!01");
      run("$01L1", "!010200");
      run("$01L0", "!FEFD00");
      run("$01L2", "?01");
      di_pins_in <= 8'h00;
      do_state_in <= 8'h00;
      run("$01C", "!01");
      run("$01L1", "!000000");
      run("$01M", "!01IO-NODE1");
      run("~01OAB", "!01");
      run("$01M", "!01AB");
      run("$01X", "?01");
      run("$02F", "");
      rx_err_in <= 1'b1;
      run("$01F", "");
      rx_err_in <= 1'b0;
      av(1'b1, 3'h0, 32'h0000_0102);
      run("$02FCD", "");
      run("$02FCC", "!02B0.356");
      av(1'b0, 3'h1, 32'h0);
      check("stat", $sformatf("%h", q), "0000013a");
      av(1'b0, 3'h5, 32'h0);
      check("unmapped", $sformatf("%h", q), "00000000");
      // second reset: storage now holds modbus, so the running copy follows it
      proto_nv_in <= 1'b1;
      reset_n_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      check("rst mask", $sformatf("%h", edge_mask_out), "00");
      reset_n_in <= 1'b1;
      repeat (5) @(posedge core_clk_in);
      check("run after", $sformatf("%b", proto_run_out), "1");
      run("$01P", "!0111");
      print_verdict();
   end
   // hang guard, well beyond the longest sequence
   initial
   begin
      #1000000;
      errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
